// File: common/brownout_reset_defines.vh
// constants for the brown-out reset control block
`ifndef BROWNOUT_RESET_DEFINES_VH
`define BROWNOUT_RESET_DEFINES_VH

// clock rate and power-up delay
`define CLK_MHZ            200
`define PWRUP_DELAY_MS     64
`define PWRUP_DELAY_CYC    (`PWRUP_DELAY_MS * 1000 * `CLK_MHZ)

// mode select encodings
`define MODE_OFF           2'b00
`define MODE_SOFT          2'b01
`define MODE_HW_SLEEPOFF   2'b10
`define MODE_ALWAYS        2'b11

// wishbone register offsets (byte addresses)
`define ADDR_CAUSE         4'h0
`define ADDR_OSC           4'h4
`define ADDR_RTCCAL        4'h8
`define ADDR_NVMCTL        4'hc

// reset cause register field positions
`define CAUSE_POR_BIT      0
`define CAUSE_BOR_BIT      1
`define CAUSE_SLEEP_BIT    3
`define CAUSE_EXT_BIT      7
`define CAUSE_SWR_BIT      6
`define CAUSE_SOFTEN_BIT   13
`define CAUSE_WMASK        16'he2df

// reset values
`define CAUSE_POR_RST      16'h0003
`define OSC_OTHER_RST      16'h0000
`define RTCCAL_RST         16'h0000
`define NVMCTL_RST         16'h0000

// oscillator control fields
`define OSC_CUR_LSB        12
`define OSC_NEW_LSB        8

`endif

// File: logic/brownout_trip_sync.v
// supply comparator synchroniser and power-up delay timer
`timescale 1ns/1ps
module brownout_trip_sync #(
	parameter DELAY_CYC = 32'd12800000
)(
	// clock and reset
	input  wire        core_clk,
	input  wire        rst_b,
	input  wire        clkEn,
	// control
	input  wire        detectOn,
	input  wire        timerOn,
	input  wire        supplyLowRaw,
	// status
	output reg         brownHold,
	output reg         tripPulse
);
	reg        syncA_q;
	reg        syncB_q;
	reg [31:0] delayCnt_q;
	reg        timing_q;

	// two-stage synchroniser, first stage feeds only the second
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			syncA_q <= 1'b0;
			syncB_q <= 1'b0;
		end
		else if (clkEn)
		begin
			syncA_q <= supplyLowRaw;
			syncB_q <= syncA_q;
		end
	end

	// hold while low, then count the power-up delay; a new drop restarts it
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			brownHold  <= 1'b0;
			tripPulse  <= 1'b0;
			delayCnt_q <= 32'h0;
			timing_q   <= 1'b0;
		end
		else if (clkEn)
		begin
			tripPulse <= 1'b0;
			if (detectOn && syncB_q)
			begin
				tripPulse  <= !brownHold || timing_q;
				brownHold  <= 1'b1;
				timing_q   <= 1'b0;
				delayCnt_q <= 32'h0;
			end
			else if (brownHold && timerOn && !timing_q && delayCnt_q == 32'h0)
			begin
				timing_q   <= 1'b1;
				delayCnt_q <= DELAY_CYC - 32'h1;
			end
			else if (timing_q)
			begin
				if (delayCnt_q == 32'h0)
				begin
					timing_q  <= 1'b0;
					brownHold <= 1'b0;
				end
				else
					delayCnt_q <= delayCnt_q - 32'h1;
			end
			else
				brownHold <= 1'b0;
		end
	end
endmodule // brownout_trip_sync

// File: logic/brownout_reset_control.v
// brown-out reset control with reset cause and reset-type register values
//
// Notes on behaviour
// R1: only four registers depend on reset kind; cause register follows reset type
// R2: oscillator control reset value comes from reset kind and initial osc select
// R3: rtc calibration and nvm control reset only on power-on
// R4: two-bit threshold and two-bit mode fields give four configurations
// R5: nonzero mode plus supply below threshold enters brown-out reset
// R6: stay in brown-out reset while supply stays low
// R7: power-up timer runs after recovery; new drop restarts it
// R8: power-up timer enable is independent of brown-out enable
// R9: mode 01 lets the soft enable bit switch detection on or off
// R10: soft enable acts only in mode 01, reads zero otherwise
// R11: trip threshold always from configuration field, never from software
// R12: enabled detection sets brown-out flag on brown-out or power-on
// R13: software clears both flags after power-on; brown-out only then proves brown-out
// R14: leaving deepest sleep sets power-on and brown-out flags
// R15: mode 10 disables detection in sleep, re-enables on wake
// R16: any reset clears core state and forces program counter to zero
// R17: software puts a jump at the reset address
// R18: power-up delay is 64 ms when enabled, zero otherwise
// R19: power-on clears all cause flags except power-on and brown-out, which set
// R20: soft enable resets to one when mode permits, forced zero otherwise
// R21: writes to cause flags only store values, never cause reset
// R22: mode 11 keeps detection on always, including sleep
// R23: comparator output is synchronised before use
`timescale 1ns/1ps
`include "brownout_reset_defines.vh"
module brownout_reset_control #(
	parameter PWRUP_CYC = `PWRUP_DELAY_CYC,
	parameter PC_W      = 24
)(
	// clock, reset, enable
	input  wire        core_clk,
	input  wire        rst_b,
	input  wire        clkEn,
	// configuration word bits
	input  wire [1:0]  brownout_threshold_select,
	input  wire [1:0]  brownout_mode_select,
	input  wire        power_up_timer,
	input  wire [2:0]  initial_osc_select,
	// supply comparator and power state
	input  wire        supplyLow,
	input  wire        sleepActive,
	input  wire        deepSleepExit,
	input  wire        extResetReq,
	input  wire        swResetReq,
	input  wire [2:0]  curOscSel,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// reset outputs
	output reg         sysResetOut,
	output reg  [PC_W-1:0] progCounter,
	output reg  [1:0]  tripLevel
);
	reg  [15:0] cause_q;
	reg  [15:0] osc_q;
	reg  [15:0] rtcCal_q;
	reg  [15:0] nvmCtl_q;
	reg         porDone_q;
	reg         holdDly_q;
	wire        brownHold;
	wire        tripPulse;
	wire        detectOn;
	wire        softMode;
	wire        anyReset;
	wire        wrHit;
	wire [15:0] wrData;

	// merge written bytes into a 16-bit register
	function [15:0] mergeBytes;
		input [15:0] old;
		input [31:0] dat;
		input [3:0]  sel;
		begin
			mergeBytes = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
		end
	endfunction

	assign softMode = (brownout_mode_select == `MODE_SOFT);
	// detection enable per mode; the soft bit matters only in soft mode
	assign detectOn = (brownout_mode_select == `MODE_ALWAYS)                       // [R22]
		| (softMode & cause_q[`CAUSE_SOFTEN_BIT])                              // [R9] [R5]
		| ((brownout_mode_select == `MODE_HW_SLEEPOFF) & !sleepActive);       // [R15]
	assign anyReset = brownHold | extResetReq | swResetReq | deepSleepExit;
	assign wrHit    = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
	assign wrData   = wb_dat_i[15:0];

	// synchroniser and power-up timer; timer enable never follows detectOn
	brownout_trip_sync #(
		.DELAY_CYC (PWRUP_CYC)                                                 // [R18]
	) u_trip (
		.core_clk     (core_clk),
		.rst_b        (rst_b),
		.clkEn        (clkEn),
		.detectOn     (detectOn),
		.timerOn      (power_up_timer),                                        // [R8] [R7]
		.supplyLowRaw (supplyLow),                                             // [R23] [R6]
		.brownHold    (brownHold),
		.tripPulse    (tripPulse)
	);

	// power-on gives cause flags por and bor set, others clear
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cause_q   <= `CAUSE_POR_RST;                                       // [R19] [R12]
			porDone_q <= 1'b0;
		end
		else if (clkEn)
		begin
			porDone_q <= 1'b1;
			// soft enable defaults to one in soft mode after power-on
			if (!porDone_q)
				cause_q[`CAUSE_SOFTEN_BIT] <= softMode;                        // [R20]
			else
			begin
				// writes only store bits; hardware sets below win over them
				if (wrHit && wb_adr_i == `ADDR_CAUSE)
					cause_q <= mergeBytes(cause_q, {16'h0, wrData & `CAUSE_WMASK},
						wb_sel_i);                                             // [R21]
				if (!softMode)
					cause_q[`CAUSE_SOFTEN_BIT] <= 1'b0;                        // [R10]
				if (tripPulse && detectOn)
					cause_q[`CAUSE_BOR_BIT] <= 1'b1;                           // [R12]
				if (deepSleepExit)
				begin
					cause_q[`CAUSE_POR_BIT] <= 1'b1;                           // [R14]
					cause_q[`CAUSE_BOR_BIT] <= 1'b1;                           // [R14]
				end
				if (extResetReq)
					cause_q[`CAUSE_EXT_BIT] <= 1'b1;                           // [R1]
				if (swResetReq)
					cause_q[`CAUSE_SWR_BIT] <= 1'b1;                           // [R1]
			end
		end
	end

	// oscillator control: configured source after por/bor, current after external or software reset
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			osc_q <= `OSC_OTHER_RST;
		else if (clkEn)
		begin
			if (!porDone_q || tripPulse)
				osc_q <= {1'b0, initial_osc_select, 1'b0, initial_osc_select, 8'h00}; // [R2]
			else if (extResetReq || swResetReq)
				osc_q <= {1'b0, curOscSel, 1'b0, curOscSel, 8'h00};            // [R2]
			else if (wrHit && wb_adr_i == `ADDR_OSC)
				osc_q <= mergeBytes(osc_q, wb_dat_i, wb_sel_i);
		end
	end

	// rtc calibration and nvm control survive all resets but power-on
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rtcCal_q <= `RTCCAL_RST;                                           // [R3]
			nvmCtl_q <= `NVMCTL_RST;                                           // [R3]
		end
		else if (clkEn && wrHit)
		begin
			if (wb_adr_i == `ADDR_RTCCAL)
				rtcCal_q <= mergeBytes(rtcCal_q, wb_dat_i, wb_sel_i);
			if (wb_adr_i == `ADDR_NVMCTL)
				nvmCtl_q <= mergeBytes(nvmCtl_q, wb_dat_i, wb_sel_i);
		end
	end

	// wishbone answer one cycle after request, ack drops the next cycle
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else if (clkEn)
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & !wb_ack_o;
			case (wb_adr_i)
				// soft enable masked on read too, so a fresh mode change never shows it
				`ADDR_CAUSE:  wb_dat_o <= {16'h0, cause_q & ~{2'b00, !softMode, 13'h0}}; // [R10]
				`ADDR_OSC:    wb_dat_o <= {16'h0, osc_q};
				`ADDR_RTCCAL: wb_dat_o <= {16'h0, rtcCal_q};
				`ADDR_NVMCTL: wb_dat_o <= {16'h0, nvmCtl_q};
				default:      wb_dat_o <= 32'h0; // unmapped reads zero, still acked
			endcase
		end
	end

	// system reset and program counter; threshold only from config
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sysResetOut <= 1'b1;
			holdDly_q   <= 1'b1;
			progCounter <= {PC_W{1'b0}};
			tripLevel   <= 2'b00;
		end
		else if (clkEn)
		begin
			tripLevel   <= brownout_threshold_select;                          // [R11] [R4]
			holdDly_q   <= anyReset;
			sysResetOut <= anyReset | holdDly_q;                               // [R5] [R6]
			// reset pins the fetch address at zero; core runs past it itself
			if (anyReset || sysResetOut)
				progCounter <= {PC_W{1'b0}};                                   // [R16]
		end
	end
endmodule // brownout_reset_control

// File: verif/brownout_reset_control_props.sv
// port assertions for the brown-out reset control
`timescale 1ns/1ps
module brownout_reset_control_props #(
	parameter PC_W = 24
)(
	// clock and reset
	input wire            core_clk,
	input wire            rst_b,
	input wire            clkEn,
	// config, supply and power state
	input wire [1:0]      brownout_threshold_select,
	input wire [1:0]      brownout_mode_select,
	input wire            power_up_timer,
	input wire            supplyLow,
	input wire            sleepActive,
	input wire            deepSleepExit,
	input wire            extResetReq,
	input wire            swResetReq,
	// bus
	input wire            wb_cyc_i,
	input wire            wb_stb_i,
	input wire            wb_we_i,
	input wire [3:0]      wb_adr_i,
	input wire [31:0]     wb_dat_o,
	input wire            wb_ack_o,
	// reset outputs
	input wire            sysResetOut,
	input wire [PC_W-1:0] progCounter,
	input wire [1:0]      tripLevel
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// request taken and no other reset source pending
	wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn;
	wire quiet = !extResetReq && !swResetReq && !deepSleepExit;
	a_ack_follows: assert property (req |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held more than one cycle");
	a_pc_cleared: assert property (sysResetOut |-> progCounter == {PC_W{1'b0}})
		else $error("program counter not zero in reset");
	a_trip_copy: assert property (clkEn && $stable(brownout_threshold_select)
		|=> tripLevel == $past(brownout_threshold_select)) else $error("trip level differs");
	a_low_resets: assert property ((brownout_mode_select == 2'b11 && supplyLow)[*5]
		|-> sysResetOut) else $error("low supply did not reset");
	a_soft_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0
		&& brownout_mode_select != 2'b01 |-> !wb_dat_o[13]) else $error("soft enable nonzero");
	a_flag_write: assert property ((!sysResetOut && !supplyLow && quiet)[*4]
		##0 (req && wb_we_i) |=> !sysResetOut) else $error("register write caused reset");
	a_sleep_off: assert property (brownout_mode_select == 2'b10 && sleepActive
		&& !sysResetOut && quiet |=> !sysResetOut) else $error("reset during sleep");
	a_pwrup_hold: assert property ($fell(supplyLow) && power_up_timer && sysResetOut
		|=> sysResetOut[*8]) else $error("power-up delay cut short");
endmodule // brownout_reset_control_props
bind brownout_reset_control brownout_reset_control_props #(.PC_W(PC_W)) props_inst (
	.core_clk(core_clk), .rst_b(rst_b), .clkEn(clkEn),
	.brownout_threshold_select(brownout_threshold_select),
	.brownout_mode_select(brownout_mode_select), .power_up_timer(power_up_timer),
	.supplyLow(supplyLow), .sleepActive(sleepActive), .deepSleepExit(deepSleepExit),
	.extResetReq(extResetReq), .swResetReq(swResetReq), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .sysResetOut(sysResetOut), .progCounter(progCounter),
	.tripLevel(tripLevel));

// File: verif/supply_comparator_model.sv
// supply comparator model driving the below-threshold flag
`timescale 1ns/1ps
module supply_comparator_model (
	// clock and threshold
	input wire       core_clk,
	input wire [1:0] tripLevel,
	// comparator output
	output reg       supplyLow = 1'b0
);
	reg dipOn = 1'b0;
	// real comparator is async; edge aligned here, the block syncs it anyway
	always @(posedge core_clk)
		supplyLow <= dipOn;
endmodule // supply_comparator_model

// File: verif/tb_brownout_reset_control.sv
// self-checking bench for the brown-out reset control
`timescale 1ns/1ps
module tb_brownout_reset_control;
	reg         core_clk = 1'b0;
	reg         rst_b = 1'b0;
	reg [1:0]   mode = 2'b01;
	reg         pwrTimer = 1'b0;
	reg         sleepOn = 1'b0;
	reg         dsExit = 1'b0;
	reg         extReq = 1'b0;
	reg         swReq = 1'b0;
	reg [1:0]   thr = 2'h2;
	reg [2:0]   curOsc = 3'h0;
	reg         cyc = 1'b0;
	reg         stb = 1'b0;
	reg         we = 1'b0;
	reg [3:0]   adr = 4'h0;
	reg [31:0]  wdat = 32'h0;
	wire [31:0] rdat;
	wire        ack, sysRst, low;
	wire [23:0] pc;
	wire [1:0]  trip;
	integer     bad_count = 0;
	integer     n_checks = 0;
	brownout_reset_control #(.PWRUP_CYC(20)) brownout_reset_control_inst (
		.core_clk(core_clk), .rst_b(rst_b), .clkEn(1'b1),
		.brownout_threshold_select(thr), .brownout_mode_select(mode),
		.power_up_timer(pwrTimer), .initial_osc_select(3'h5), .supplyLow(low),
		.sleepActive(sleepOn), .deepSleepExit(dsExit), .extResetReq(extReq),
		.swResetReq(swReq), .curOscSel(curOsc), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .sysResetOut(sysRst), .progCounter(pc),
		.tripLevel(trip));
	supply_comparator_model cmp (.core_clk(core_clk), .tripLevel(trip), .supplyLow(low));
	// clock
	initial
	begin
		forever #2.5 core_clk = ~core_clk;
	end
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", n_checks, bad_count);
			if (bad_count == 0 && n_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (seen !== exp)
			begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge core_clk);
	endtask
	// bounded wait for the reset output to reach v; n counts cycles
	task wait_rst(input v, output integer n);
		begin
			n = 0;
			do
			begin
				@(negedge core_clk);
				n = n + 1;
			end
			while (sysRst !== v && n < 200);
			if (sysRst !== v)
			begin
				bad_count = bad_count + 1;
				print_verdict;
			end
			@(posedge core_clk);
		end
	endtask
	// one classic cycle; request held until the edge that samples ack high
	task bus(input w, input [3:0] a, input [15:0] d, output [31:0] r);
		integer i;
		begin
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			wdat <= {16'h0000, d};
			i = 0;
			// read right after the edge: ack and data are what that edge sampled
			do
			begin
				@(posedge core_clk);
				i = i + 1;
			end
			while (ack !== 1'b1 && i < 50);
			if (ack !== 1'b1)
			begin
				bad_count = bad_count + 1;
				print_verdict;
			end
			r = rdat;
			cyc <= 1'b0;
			stb <= 1'b0;
			// idle one cycle so the next request never rises in this step
			@(posedge core_clk);
		end
	endtask
	task t_reset;
		reg [31:0] r;
		begin
			bus(0, 4'h0, 16'h0, r);
			chk(r, 32'h2003);
			bus(0, 4'h4, 16'h0, r);
			chk(r, 32'h5500);
			bus(0, 4'h8, 16'h0, r);
			chk(r, 32'h0);
			bus(0, 4'hc, 16'h0, r);
			chk(r, 32'h0);
			bus(0, 4'h2, 16'h0, r);
			chk(r, 32'h0);
			chk(pc, 24'h0);
			chk(trip, 2'h2);
			$display("test reset values done");
		end
	endtask
	// m 4 is soft mode with the enable cleared
	task t_modes(input sl);
		integer m, n;
		reg [31:0] r;
		reg exp;
		begin
			sleepOn <= sl;
			for (m = 0; m < 5; m = m + 1)
			begin
				mode <= (m == 4) ? 2'b01 : m[1:0];
				bus(1, 4'h0, (m == 4) ? 16'h0000 : 16'h2000, r);
				bus(0, 4'h0, 16'h0, r);
				chk(r[13], m == 1);
				// soft mode with the enable set keeps detecting in sleep too
				exp = m == 3 || m == 1 || (!sl && m == 2);
				cmp.dipOn <= 1'b1;
				tick(10);
				chk(sysRst, exp);
				cmp.dipOn <= 1'b0;
				tick(4);
				wait_rst(0, n);
				chk(n < 10, 1);
				bus(0, 4'h0, 16'h0, r);
				chk(r[1], exp);
			end
			sleepOn <= 1'b0;
			$display("test modes done, sleep %0d", sl);
		end
	endtask
	task t_other;
		integer n;
		reg [31:0] r;
		begin
			mode <= 2'b11;
			bus(1, 4'h8, 16'h1234, r);
			bus(1, 4'h0, 16'h0000, r);
			curOsc <= 3'h2;
			extReq <= 1'b1;
			swReq <= 1'b1;
			tick(1);
			extReq <= 1'b0;
			swReq <= 1'b0;
			wait_rst(1, n);
			wait_rst(0, n);
			bus(0, 4'h4, 16'h0, r);
			chk(r, 32'h2200);
			bus(0, 4'h8, 16'h0, r);
			chk(r, 32'h1234);
			bus(0, 4'h0, 16'h0, r);
			chk(r[7:0], 8'hc0);
			thr <= 2'h1;
			tick(2);
			chk(trip, 2'h1);
			dsExit <= 1'b1;
			tick(1);
			dsExit <= 1'b0;
			tick(4);
			wait_rst(0, n);
			bus(0, 4'h0, 16'h0, r);
			chk(r[1:0], 2'h3);
			// drop again mid-delay so the timer has to restart
			pwrTimer <= 1'b1;
			cmp.dipOn <= 1'b1;
			tick(10);
			cmp.dipOn <= 1'b0;
			tick(10);
			cmp.dipOn <= 1'b1;
			tick(4);
			chk(sysRst, 1);
			cmp.dipOn <= 1'b0;
			wait_rst(0, n);
			chk(n >= 20 && n <= 30, 1);
			$display("test other resets done");
		end
	endtask
	initial
	begin
		integer n;
		tick(5);
		rst_b <= 1'b1;
		wait_rst(0, n);
		t_reset;
		t_modes(0);
		t_modes(1);
		t_other;
		print_verdict;
	end
endmodule // tb_brownout_reset_control
